// ### hw/orsl_pkg.sv
package orsl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int KEY_HOLD_S    = 3;
  localparam int KEY_HOLD_MS   = KEY_HOLD_S * 1000;
  localparam int REMIND_MIN    = 5;
  localparam int REMIND_MS     = REMIND_MIN * 60 * 1000;
  localparam int FLASH_MS      = 250;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LSN    = 8'h04;
  localparam logic [7:0] OFS_LSL    = 8'h08;
  localparam logic [7:0] OFS_HSN    = 8'h0C;
  localparam logic [7:0] OFS_HSL    = 8'h10;
  localparam logic [7:0] OFS_LDLY   = 8'h14;
  localparam logic [7:0] OFS_HDLY   = 8'h18;
  localparam logic [7:0] OFS_RSTT   = 8'h1C;
  localparam logic [7:0] OFS_UV     = 8'h20;
  localparam logic [7:0] OFS_ADDR   = 8'h24;
  localparam logic [7:0] OFS_ASSIGN = 8'h28;
  localparam logic [7:0] OFS_CMD    = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_FREQ60  = 2;
  localparam int CTRL_LBLK    = 3;
  localparam int CTRL_HBLK    = 4;
  localparam logic [15:0] HS_EXIT_VAL  = 16'hFFFF;
  localparam logic [15:0] RST_ASSIGN   = 16'h1412;
  localparam logic [15:0] RST_LSN      = 16'h0140;
  localparam logic [15:0] RST_LSL      = 16'h0100;
  localparam logic [15:0] RST_HSN      = 16'h0400;
  localparam logic [15:0] RST_HSL      = 16'h0300;
  localparam logic [15:0] RST_LDLY     = 16'h01F4;
  localparam logic [15:0] RST_HDLY     = 16'h0064;
  localparam logic [15:0] RST_UV       = 16'h0050;
  localparam logic [5:0]  ADDR_MIN     = 6'h01;
  localparam logic [5:0]  ADDR_MAX     = 6'h20;
  localparam logic [15:0] FAST_DEFINITE_TIME_CURVE_MS = 16'h0001;
  localparam logic [15:0] FAST_INV_MS  = 16'h0032;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    DEFINITE_TIME_CURVE,
    NORMAL_INVERSE_CURVE,
    VERY_INVERSE_CURVE,
    EXTREMELY_INVERSE_CURVE
  } orsl_curve_t;
endpackage

// ### hw/orsl_top.sv
// Summary of operation
// RQ1: Choosing a curve jumps to the low-set delay and flashes its reminder indicator.
// RQ2: Curve changed, delay untouched for five minutes: load the curve's fastest delay.
// RQ3: Inverse curves with nonzero reset time clear timing after that fault-free time.
// RQ4: Zero reset time clears the delay timer at once; it restarts from zero.
// RQ5: High-set threshold is setting times nominal current; exit value disables it.
// RQ6: High-set element always uses a definite delay, whatever the low-set curve.
// RQ7: Nominal frequency 50 or 60 is stored and handed to sampling and filtering.
// RQ8: Serial slave address accepts only values 1 through 32.
// RQ9: External blocking suppresses elements set blocked; not-blocked elements keep working.
// RQ10: Default blocking: low-set not blocked, high-set blocked.
// RQ11: Five relays; fifth is energised supervision alarm, relays 1 to 4 assignable.
// RQ12: Alarm-assigned relays energise at element pickup without waiting for delay.
// RQ13: Trip-assigned relays energise only after the full delay with pickup persisting.
// RQ14: Each element has separate alarm and trip subsets of four relays, changeable.
// RQ15: Defaults: low alarm relay 2, low trip relay 1, high alarm 3, high trip 1.
// RQ16: Changed blocking or assignment values need enter and password from the operator; the design applies them directly on the register write.
// RQ17: Pickup lights element indicator yellow and flashes faulty phase indicators red.
// RQ18: On trip the faulty phase indicators turn from flashing to steady red.
// RQ19: With jumper set, reset by 3 s key hold, reset input, or serial command.
// RQ20: Reset clears trip indication only when no element is picked up.
// RQ21: Resetting display and relays leaves all settings unchanged.
// RQ22: Normal thresholds at healthy voltage; low-voltage thresholds below undervoltage set point.
// RQ23: Low-set curve is definite, normal, very or extremely inverse.
// RQ24: Pickup when any phase exceeds active threshold; exceeding phases recorded as faulty.
`timescale 1ns/1ps
`default_nettype none
module orsl_top
  import orsl_pkg::*;
#(
  parameter int          CYC_PER_MS_P  = CYC_PER_MS,
  parameter int          KEY_HOLD_MS_P = KEY_HOLD_MS,
  parameter int          REMIND_MS_P   = REMIND_MS,
  parameter logic [15:0] NOM_CURRENT   = 16'h0100
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [15:0] cur_l1_i,
  input  wire logic [15:0] cur_l2_i,
  input  wire logic [15:0] cur_l3_i,
  input  wire logic [15:0] voltage_i,
  input  wire logic        ext_block_i,
  input  wire logic        ext_reset_i,
  input  wire logic        reset_key_i,
  input  wire logic        reset_enable_jumper_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       relay_o,
  output logic             supervision_relay_o,
  output logic             led_low_yellow_o,
  output logic             led_high_yellow_o,
  output logic [2:0]       led_phase_red_o,
  output logic             led_delay_flash_o,
  output logic             freq_60_o,
  output logic [5:0]       slave_addr_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  s1, s2;
    logic        aw_held, w_held, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    orsl_curve_t curve;
    logic        freq60, lblk, hblk;
    logic [15:0] lsn, lsl, hsn, hsl, ldly, hdly, rstt, uv, asg;
    logic [5:0]  addr;
    logic        remind, touched;
    logic [19:0] remind_ms, key_ms, ltim, lidle, htim, flash_ms;
    logic [15:0] pre;
    logic        ltrip, htrip, flash;
    logic [2:0]  faulty;
    logic [3:0]  relay;
    logic        sup, led_l, led_h, srl_rst, dflash;
    logic [2:0]  led_ph;
  } orsl_state_t;
  orsl_state_t st, next_st;
  logic [1:0]  rst_q;
  logic        rst_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];
  // ----------------------------------------------------------------
  // Measurement compare
  // ----------------------------------------------------------------
  logic        uv_low, ms_tick, lpick, hpick, blk, hs_off, rst_req, wr_ctrl_q;
  logic [2:0]  lph, hph;
  logic [15:0] lset, hset;
  logic [31:0] lthr, hthr;
  logic [31:0] cur [3];
  assign cur[0] = {8'h00, cur_l1_i, 8'h00};
  assign cur[1] = {8'h00, cur_l2_i, 8'h00};
  assign cur[2] = {8'h00, cur_l3_i, 8'h00};
  assign uv_low = voltage_i < st.uv; // RQ22
  assign lset   = uv_low ? st.lsl : st.lsn; // RQ22
  assign hset   = uv_low ? st.hsl : st.hsn;
  assign lthr   = lset * NOM_CURRENT;
  assign hthr   = hset * NOM_CURRENT; // RQ5
  assign hs_off = hset == HS_EXIT_VAL; // RQ5
  assign blk    = st.s2[0];
  for (genvar p = 0; p < 3; p++) begin : g_ph
    assign lph[p] = cur[p] > lthr; // RQ24
    assign hph[p] = cur[p] > hthr && !hs_off;
  end
  assign lpick   = |lph && !(blk && st.lblk); // RQ9
  assign hpick   = |hph && !(blk && st.hblk); // RQ9
  assign ms_tick = st.pre == 16'(CYC_PER_MS_P - 1);
  assign rst_req = st.s2[3] && (st.key_ms == 20'(KEY_HOLD_MS_P) || st.s2[1] || st.srl_rst); // RQ19
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        wr, rd;
    logic [31:0] d;
    next_st = st;
    wr = 1'b0;
    rd = 1'b0;
    d  = 32'h0;
    next_st.s1 = {reset_enable_jumper_i, reset_key_i, ext_reset_i, ext_block_i};
    next_st.s2 = st.s1;
    next_st.srl_rst = 1'b0;
    // AXI4-Lite write channel; address and data may come in either order.
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      wr = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;
    if (wr) begin
      d = st.wdata;
      unique case (st.awaddr)
        OFS_CTRL: begin
          if (orsl_curve_t'(d[1:0]) != st.curve) begin
            next_st.remind    = 1'b1; // RQ1
            next_st.touched   = 1'b0;
            next_st.remind_ms = 20'h0;
          end
          next_st.curve  = orsl_curve_t'(d[1:0]); // RQ23
          next_st.freq60 = d[CTRL_FREQ60]; // RQ7
          next_st.lblk   = d[CTRL_LBLK];
          next_st.hblk   = d[CTRL_HBLK];
        end
        OFS_LSN:  next_st.lsn = d[15:0];
        OFS_LSL:  next_st.lsl = d[15:0];
        OFS_HSN:  next_st.hsn = d[15:0];
        OFS_HSL:  next_st.hsl = d[15:0];
        OFS_LDLY: begin
          next_st.ldly    = d[15:0];
          next_st.touched = 1'b1;
          next_st.remind  = 1'b0;
        end
        OFS_HDLY: next_st.hdly = d[15:0];
        OFS_RSTT: next_st.rstt = d[15:0];
        OFS_UV:   next_st.uv   = d[15:0];
        OFS_ADDR: begin
          if (d[5:0] >= ADDR_MIN && d[5:0] <= ADDR_MAX && d[31:6] == 26'h0) begin
            next_st.addr = d[5:0]; // RQ8
          end
        end
        OFS_ASSIGN: next_st.asg = d[15:0]; // RQ14
        OFS_CMD:    next_st.srl_rst = d[0]; // RQ19
        default:    next_st.bresp = RESP_SLVERR;
      endcase
    end
    // AXI4-Lite read channel.
    if (s_axi_arvalid && st.arready) begin
      rd = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:   next_st.rdata = {27'h0, st.hblk, st.lblk, st.freq60, st.curve};
        OFS_LSN:    next_st.rdata = {16'h0, st.lsn};
        OFS_LSL:    next_st.rdata = {16'h0, st.lsl};
        OFS_HSN:    next_st.rdata = {16'h0, st.hsn};
        OFS_HSL:    next_st.rdata = {16'h0, st.hsl};
        OFS_LDLY:   next_st.rdata = {16'h0, st.ldly};
        OFS_HDLY:   next_st.rdata = {16'h0, st.hdly};
        OFS_RSTT:   next_st.rdata = {16'h0, st.rstt};
        OFS_UV:     next_st.rdata = {16'h0, st.uv};
        OFS_ADDR:   next_st.rdata = {26'h0, st.addr};
        OFS_ASSIGN: next_st.rdata = {16'h0, st.asg};
        OFS_CMD:    next_st.rdata = 32'h0;
        OFS_STATUS: next_st.rdata = {18'h0, uv_low, st.remind, st.faulty, st.htrip,
                                     st.ltrip, hpick, lpick, st.sup, st.relay};
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid && !rd;
    // Millisecond time base; every protection timer counts these ticks.
    next_st.pre = ms_tick ? 16'h0 : st.pre + 16'h1;
    if (ms_tick) begin
      next_st.flash_ms = st.flash_ms + 20'h1;
      if (st.flash_ms == 20'(FLASH_MS - 1)) begin
        next_st.flash_ms = 20'h0;
        next_st.flash    = !st.flash;
      end
    end
    // Reminder: the delay must be revisited after a curve change.
    if (st.remind && ms_tick && !wr) begin
      next_st.remind_ms = st.remind_ms + 20'h1;
      if (st.remind_ms == 20'(REMIND_MS_P - 1) && !st.touched) begin
        next_st.remind = 1'b0; // RQ2
        next_st.ldly   = st.curve == DEFINITE_TIME_CURVE ? FAST_DEFINITE_TIME_CURVE_MS : FAST_INV_MS; // RQ2
      end
    end
    // Key hold timer; releasing the key restarts it.
    if (!st.s2[2]) begin
      next_st.key_ms = 20'h0;
    end else if (ms_tick && st.key_ms != 20'(KEY_HOLD_MS_P)) begin
      next_st.key_ms = st.key_ms + 20'h1;
    end
    // Low-set element. Inverse curves with nonzero reset time keep accumulated time through short gaps.
    if (lpick) begin
      next_st.lidle = 20'h0;
      if (ms_tick && st.ltim < {4'h0, st.ldly}) begin
        next_st.ltim = st.ltim + 20'h1;
      end
      if (st.ltim >= {4'h0, st.ldly}) begin
        next_st.ltrip = 1'b1; // RQ13
      end
    end else if (st.curve == DEFINITE_TIME_CURVE || st.rstt == 16'h0) begin
      next_st.ltim = 20'h0; // RQ4
    end else if (ms_tick) begin
      next_st.lidle = st.lidle + 20'h1;
      if (st.lidle + 20'h1 >= {4'h0, st.rstt}) begin
        next_st.ltim  = 20'h0; // RQ3
        next_st.lidle = 20'h0;
      end
    end
    // High-set element: definite delay only, whatever the low-set curve.
    if (hpick) begin
      if (ms_tick && st.htim < {4'h0, st.hdly}) begin
        next_st.htim = st.htim + 20'h1; // RQ6
      end
      if (st.htim >= {4'h0, st.hdly}) begin
        next_st.htrip = 1'b1; // RQ13
      end
    end else begin
      next_st.htim = 20'h0; // RQ6
    end
    if (lpick || hpick) begin
      next_st.faulty = st.faulty | (lpick ? lph : 3'h0) | (hpick ? hph : 3'h0); // RQ24
    end
    // Reset touches only indication and relay state, never settings.
    if (rst_req && !lpick && !hpick) begin
      next_st.ltrip  = 1'b0; // RQ20
      next_st.htrip  = 1'b0; // RQ21
      next_st.faulty = 3'h0;
    end
    next_st.relay = (lpick ? st.asg[3:0] : 4'h0) | (hpick ? st.asg[11:8] : 4'h0) | // RQ12
                    (st.ltrip ? st.asg[7:4] : 4'h0) | (st.htrip ? st.asg[15:12] : 4'h0); // RQ13
    next_st.sup    = 1'b1; // RQ11
    next_st.led_l  = lpick; // RQ17
    next_st.led_h  = hpick; // RQ17
    next_st.led_ph = (st.ltrip || st.htrip) ? st.faulty : (st.flash ? st.faulty : 3'h0); // RQ18
    next_st.dflash = next_st.remind && next_st.flash; // RQ1
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.curve <= DEFINITE_TIME_CURVE;
      st.hblk  <= 1'b1; // RQ10
      st.lblk  <= 1'b0; // RQ10
      st.asg   <= RST_ASSIGN; // RQ15
      st.lsn   <= RST_LSN;
      st.lsl   <= RST_LSL;
      st.hsn   <= RST_HSN;
      st.hsl   <= RST_HSL;
      st.ldly  <= RST_LDLY;
      st.hdly  <= RST_HDLY;
      st.uv    <= RST_UV;
      st.addr  <= ADDR_MIN;
      st.touched <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  assign s_axi_awready       = st.awready;
  assign s_axi_wready        = st.wready;
  assign s_axi_bvalid        = st.bvalid;
  assign s_axi_bresp         = st.bresp;
  assign s_axi_arready       = st.arready;
  assign s_axi_rvalid        = st.rvalid;
  assign s_axi_rdata         = st.rdata;
  assign s_axi_rresp         = st.rresp;
  assign relay_o             = st.relay; // RQ11
  assign supervision_relay_o = st.sup;
  assign led_low_yellow_o    = st.led_l;
  assign led_high_yellow_o   = st.led_h;
  assign led_phase_red_o     = st.led_ph;
  assign led_delay_flash_o   = st.dflash; // RQ1
  assign freq_60_o           = st.freq60; // RQ7
  assign slave_addr_o        = st.addr; // RQ8
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  sequence s_curve_wr;
    wr_ctrl_q && (orsl_curve_t'(st.wdata[1:0]) != st.curve);
  endsequence
  sequence s_remind_on;
    st.remind && !st.touched;
  endsequence
  assign wr_ctrl_q = st.aw_held && st.w_held && !st.bvalid && st.awaddr == OFS_CTRL;
  a_curve_reminder: assert property (s_curve_wr |=> s_remind_on) // RQ1
    else $error("curve change did not raise reminder");
  a_addr_range: assert property (st.addr >= ADDR_MIN && st.addr <= ADDR_MAX) // RQ8
    else $error("slave address out of range");
  a_sup_relay: assert property ($past(rst_n) |-> supervision_relay_o) // RQ11
    else $error("supervision relay not energised");
  a_alarm_pickup: assert property (lpick && st.asg[3:0] != 4'h0 |=> (relay_o & $past(st.asg[3:0])) != 4'h0) // RQ12
    else $error("alarm relay missing at pickup");
  a_trip_delay: assert property ($rose(st.ltrip) |-> $past(lpick) && $past(st.ltim) >= {4'h0, $past(st.ldly)}) // RQ13
    else $error("low-set trip before delay");
  a_block_high: assert property (blk && st.hblk |-> !hpick) // RQ9
    else $error("blocked high-set picked up");
  a_exit_off: assert property (hs_off |-> !hpick) // RQ5
    else $error("high-set active at exit value");
  a_reset_hold: assert property (st.ltrip && (lpick || hpick) |=> st.ltrip) // RQ20
    else $error("trip cleared while picked up");
  a_zero_rst: assert property (!lpick && st.rstt == 16'h0 |=> st.ltim == 20'h0) // RQ4
    else $error("timer kept with zero reset time");
  a_steady_red: assert property (st.ltrip || st.htrip |=> led_phase_red_o == $past(st.faulty)) // RQ18
    else $error("faulty phase led not steady");
endmodule
`default_nettype wire

// ### verification/orsl_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Measurement front end
// ----------------------------------------------------------------
module orsl_fe_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  fault_i,
  input  wire logic [15:0] amp_i,
  input  wire logic        uv_i,
  output logic [15:0]      cur_l1_o,
  output logic [15:0]      cur_l2_o,
  output logic [15:0]      cur_l3_o,
  output logic [15:0]      voltage_o
);
  // Healthy phases carry a light load, so a fault is a real step and not a rise from zero.
  localparam logic [15:0] LOAD_CUR = 16'h0040;
  always_ff @(posedge clk_i) begin
    cur_l1_o  <= fault_i[0] ? amp_i : LOAD_CUR;
    cur_l2_o  <= fault_i[1] ? amp_i : LOAD_CUR;
    cur_l3_o  <= fault_i[2] ? amp_i : LOAD_CUR;
    voltage_o <= uv_i ? 16'h0010 : 16'h0100;
  end
endmodule
`default_nettype wire

// ### verification/orsl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module orsl_top_tb;
  import orsl_pkg::*;
  logic        clk, rstn, blk, key, jmp, uv, erst;
  logic [2:0]  flt, red;
  logic [15:0] amp, c1, c2, c3, volt;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  relay;
  logic        sup, lyel, hyel, dflash, f60;
  logic [5:0]  saddr;
  int          err_count, tests_run, n;
  // ----------------------------------------------------------------
  // Design and front end
  // ----------------------------------------------------------------
  orsl_fe_model fe_u (.clk_i(clk), .fault_i(flt), .amp_i(amp), .uv_i(uv), .cur_l1_o(c1), .cur_l2_o(c2),
    .cur_l3_o(c3), .voltage_o(volt));
  orsl_top #(.CYC_PER_MS_P(10), .KEY_HOLD_MS_P(3), .REMIND_MS_P(300)) dut_u (.clk_i(clk), .resetn_i(rstn),
    .cur_l1_i(c1), .cur_l2_i(c2), .cur_l3_i(c3), .voltage_i(volt), .ext_block_i(blk), .ext_reset_i(erst),
    .reset_key_i(key), .reset_enable_jumper_i(jmp), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .relay_o(relay),
    .supervision_relay_o(sup), .led_low_yellow_o(lyel), .led_high_yellow_o(hyel), .led_phase_red_o(red),
    .led_delay_flash_o(dflash), .freq_60_o(f60), .slave_addr_o(saddr));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    err_count++;
    $display("mismatch at %0t ns: wait ran out", $time);
    close_out();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One edge first, so a release from the previous transfer never meets a new request in one step.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 200);
    if (k == 200) hang();
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 200);
    if (k == 200) hang();
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    chk(32'(sup), 32'h1, "supervision relay not energised");
    chk(32'(relay), 32'h0, "assignable relay energised at rest");
    axr(OFS_CTRL);
    chk(rd & 32'h0000001F, 32'h00000010, "blocking defaults");
    axr(OFS_ASSIGN);
    chk(rd & 32'h0000FFFF, 32'h00001412, "assignment defaults");
    axr(8'h3C);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped read accepted");
    $display("test defaults done");
  endtask
  task automatic t_trip();
    axw(OFS_LDLY, 32'h00000003);
    flt <= 3'b010;
    amp <= 16'h0200;
    cyc(15);
    chk(32'(relay), 32'h2, "alarm relay at pickup, no early trip");
    chk(32'(lyel), 32'h1, "low-set indicator off at pickup");
    flt <= 3'b000;
    cyc(5);
    chk(32'(relay), 32'h0, "alarm relay held after fault gone");
    flt <= 3'b010;
    n = 0;
    while (relay[0] !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n == 300) hang();
    chk(32'(n >= 22 && n <= 45), 32'h1, "trip time after restarted timer");
    cyc(3);
    chk(32'(red), 32'h2, "faulty phase not steady after trip");
    cyc(2600);
    chk(32'(red), 32'h2, "faulty phase flashes after trip");
    $display("test trip done");
  endtask
  task automatic t_reset();
    axw(OFS_CMD, 32'h1);
    cyc(5);
    chk(32'(relay[0]), 32'h1, "trip cleared while picked up");
    flt <= 3'b000;
    jmp <= 1'b0;
    axw(OFS_CMD, 32'h1);
    cyc(5);
    chk(32'(relay[0]), 32'h1, "reset honoured without jumper");
    jmp <= 1'b1;
    key <= 1'b1;
    cyc(12);
    chk(32'(relay[0]), 32'h1, "short key press reset");
    cyc(35);
    key <= 1'b0;
    cyc(3);
    chk(32'(relay), 32'h0, "long key hold did not reset relays");
    chk(32'(red), 32'h0, "fault indication not cleared");
    axr(OFS_LDLY);
    chk(rd & 32'h0000FFFF, 32'h3, "setting altered by reset");
    $display("test reset done");
  endtask
  task automatic t_block();
    blk <= 1'b1;
    flt <= 3'b100;
    amp <= 16'h0500;
    cyc(8);
    chk(32'({lyel, hyel, relay[2]}), 32'h4, "blocking of elements");
    blk <= 1'b0;
    cyc(8);
    chk(32'({hyel, relay[2]}), 32'h3, "high-set pickup and alarm");
    axw(OFS_HSN, 32'h0000FFFF);
    cyc(4);
    chk(32'(hyel), 32'h0, "high-set active at exit value");
    flt <= 3'b000;
    cyc(3);
    axw(OFS_CMD, 32'h1);
    cyc(5);
    chk(32'(relay), 32'h0, "serial reset failed");
    uv <= 1'b1;
    flt <= 3'b001;
    amp <= 16'h0120;
    cyc(8);
    chk(32'(lyel), 32'h1, "low-voltage threshold unused");
    uv <= 1'b0;
    cyc(8);
    chk(32'(lyel), 32'h0, "normal threshold unused");
    amp <= 16'h0200;
    cyc(45);
    chk(32'(relay[0]), 32'h1, "low-set trip missing");
    flt <= 3'b000;
    erst <= 1'b1;
    cyc(6);
    erst <= 1'b0;
    chk(32'(relay), 32'h0, "electrical reset failed");
    $display("test block done");
  endtask
  task automatic t_settings();
    axw(OFS_ADDR, 32'h21);
    cyc(2);
    chk(32'(saddr), 32'h01, "address above 32 taken");
    axw(OFS_ADDR, 32'h20);
    cyc(2);
    chk(32'(saddr), 32'h20, "address 32 refused");
    axw(OFS_CTRL, 32'h14);
    cyc(2);
    chk(32'(f60), 32'h1, "frequency 60 not stored");
    axw(OFS_STATUS, 32'h0);
    chk(32'(rs), 32'(RESP_SLVERR), "status write accepted");
    for (int c = 0; c < 4; c++) begin
      axw(OFS_CTRL, 32'h10 | 32'(c));
      axr(OFS_CTRL);
      chk(rd & 32'h3, 32'(c), "curve readback");
    end
    $display("test settings done");
  endtask
  task automatic t_remind();
    axw(OFS_CTRL, 32'h11);
    axr(OFS_STATUS);
    chk(32'(rd[12]), 32'h1, "no reminder after curve change");
    n = 0;
    while (dflash !== 1'b1 && n < 2900) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 2900), 32'h1, "reminder indicator never flashed");
    cyc(3100);
    chk(32'(dflash), 32'h0, "reminder still flashing");
    axr(OFS_LDLY);
    chk(rd & 32'h0000FFFF, 32'h32, "fastest inverse delay not loaded");
    $display("test remind done");
  endtask
  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A stuck run is cut short well inside the cycle budget.
  initial begin
    #2500000;
    hang();
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    {rstn, blk, key, uv, erst, flt, amp, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    jmp = 1'b1;
    cyc(3);
    rstn <= 1'b1;
    cyc(4);
    t_defaults();
    t_trip();
    t_reset();
    t_block();
    t_settings();
    t_remind();
    close_out();
  end
endmodule
`default_nettype wire
